// *** logic/ofs_pkg.sv ***
package ofs_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_OUT_OFF = 12'h000;
  localparam logic [11:0] OFS_KIND_OFF = 12'h004;
  localparam logic [11:0] OFS_PAT_OFF = 12'h008;
  localparam logic [11:0] OFS_DELAY_OFF = 12'h00C;
  localparam logic [11:0] OFS_COMMIT_OFF = 12'h010;
  localparam logic [11:0] OFS_STAT_OFF = 12'h014;
  localparam logic [11:0] OFS_IRQ_OFF = 12'h018;
  localparam logic [11:0] OFS_MASK_OFF = 12'h01C;
  localparam logic [11:0] OFS_KEEP_OFF = 12'h020;
  // Field positions
  localparam int OFS_COMMIT_BIT = 0;
  localparam int OFS_IRQ_ENTER_BIT = 0;
  localparam int OFS_IRQ_LEAVE_BIT = 1;
  localparam int OFS_IRQ_LOST_BIT = 2;
  // Fail-safe kind codes
  localparam logic [1:0] OFS_KIND_OFF_ALL = 2'h1;
  localparam logic [1:0] OFS_KIND_PATTERN = 2'h2;
  localparam logic [1:0] OFS_KIND_HOLD = 2'h3;
  // Reset values
  localparam logic [1:0] OFS_KIND_RST = 2'h1;
  localparam logic [7:0] OFS_DELAY_RST = 8'h00;
  localparam logic [23:0] OFS_PAT_RST = 24'h00_0000;
  localparam logic [23:0] OFS_OUT_RST = 24'h00_0000;
  // Timing: clock and delay unit
  localparam longint OFS_CLK_HZ = 20000000;
  localparam longint OFS_TENTH_MS = 100;
  localparam longint OFS_TENTH_CYC = OFS_CLK_HZ * OFS_TENTH_MS / 1000;
  // Supervision window, default one second
  localparam longint OFS_WATCH_MS = 1000;
  localparam longint OFS_WATCH_CYC = OFS_CLK_HZ * OFS_WATCH_MS / 1000;
  // Active fail-safe configuration
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] delay;
    logic [23:0] pattern;
  } ofs_cfg_t;
endpackage

// *** logic/ofs_port.sv ***
`timescale 1ns/1ps
// Functional notes
// [R1] Outputs follow written values in normal operation
// [R2] 24 points, bit/byte/word/dword write access; code writes whole pstrb byte lanes only, no bit access
// [R3] Host loss leads to fail-safe state
// [R4] Kind 1 turns every point off
// [R5] Kind 2 drives points from pattern
// [R6] Kind 3 holds last output values
// [R7] Pattern only used in kind 2
// [R8] Pattern one is on, zero off
// [R9] Pattern bits map to same point index
// [R10] Wait committed delay before fail-safe
// [R11] Delay is tenths of second, max 255
// [R12] Code 0 immediate, code 1 is 0.1s
// [R13] Kind staged until commit
// [R14] Pattern staged until commit
// [R15] Commit moves kind, delay, pattern together
// [R16] Commit one sends, zero does nothing
// [R17] Commit flag clears itself after transfer
// [R18] Quiet window means lost, transaction restarts
// [R19] Resume leaves fail-safe; reset kind off
module ofs_port #(
  parameter longint TENTH_CYC = ofs_pkg::OFS_TENTH_CYC,
  parameter longint WATCH_CYC = ofs_pkg::OFS_WATCH_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [23:0] out_points,
  output logic failsafe_active,
  output logic irq
);
  localparam logic [1:0] KIND_INVALID = 2'h0;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode
  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign acc = psel & penable & pready;
  assign wr = acc & pwrite;
  assign rd = acc & ~pwrite;

  // Merge written byte lanes into a 24-bit field
  function automatic logic [23:0] lane_merge(input logic [23:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] s);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  always_comb begin
    unique case (paddr)
      ofs_pkg::OFS_OUT_OFF, ofs_pkg::OFS_KIND_OFF, ofs_pkg::OFS_PAT_OFF,
      ofs_pkg::OFS_DELAY_OFF, ofs_pkg::OFS_COMMIT_OFF,
      ofs_pkg::OFS_STAT_OFF, ofs_pkg::OFS_IRQ_OFF,
      ofs_pkg::OFS_MASK_OFF, ofs_pkg::OFS_KEEP_OFF: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [23:0] host_out_reg;
  logic [1:0] kind_stage_reg;
  logic [7:0] delay_stage_reg;
  logic [23:0] pat_stage_reg;
  logic commit_reg;
  ofs_pkg::ofs_cfg_t cfg_reg;
  logic [2:0] irq_stat_reg;
  logic [2:0] irq_mask_reg;
  logic [23:0] out_reg;
  logic fs_reg;
  logic lost_reg;

  // Host-written point values, lane strobes select bytes/words
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_out_reg <= ofs_pkg::OFS_OUT_RST;
    end else if (wr && paddr == ofs_pkg::OFS_OUT_OFF) begin
      host_out_reg <= lane_merge(host_out_reg, pwdata, pstrb); // [R2]
    end
  end

  // Staged fail-safe settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kind_stage_reg <= ofs_pkg::OFS_KIND_RST;
      delay_stage_reg <= ofs_pkg::OFS_DELAY_RST;
      pat_stage_reg <= ofs_pkg::OFS_PAT_RST;
    end else if (wr) begin
      if (paddr == ofs_pkg::OFS_KIND_OFF && pstrb[0]) begin
        kind_stage_reg <= pwdata[1:0]; // [R13]
      end
      if (paddr == ofs_pkg::OFS_DELAY_OFF && pstrb[0]) begin
        delay_stage_reg <= pwdata[7:0]; // [R11]
      end
      if (paddr == ofs_pkg::OFS_PAT_OFF) begin
        pat_stage_reg <= lane_merge(pat_stage_reg, pwdata, pstrb); // [R9] [R14]
      end
    end
  end

  // Commit flag: set by writing one, clears after transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      commit_reg <= 1'b0;
    end else if (commit_reg) begin
      commit_reg <= 1'b0; // [R17]
    end else if (wr && paddr == ofs_pkg::OFS_COMMIT_OFF && pstrb[0]) begin
      commit_reg <= pwdata[ofs_pkg::OFS_COMMIT_BIT]; // [R16]
    end
  end

  // Active configuration, loaded as one unit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= '{kind: ofs_pkg::OFS_KIND_RST, // [R19]
                   delay: ofs_pkg::OFS_DELAY_RST,
                   pattern: ofs_pkg::OFS_PAT_RST};
    end else if (commit_reg) begin
      cfg_reg <= '{kind: kind_stage_reg, delay: delay_stage_reg,
                   pattern: pat_stage_reg}; // [R15]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Supervision window and delay counting
  logic [31:0] watch_cnt_reg;
  logic [31:0] tenth_cnt_reg;
  logic [7:0] tenths_reg;
  logic host_seen;
  logic enter_now;
  assign host_seen = acc;

  // Quiet-window counter, restarted by every transaction
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      watch_cnt_reg <= 32'h0000_0000;
      lost_reg <= 1'b0;
    end else if (host_seen) begin
      watch_cnt_reg <= 32'h0000_0000; // [R18]
      lost_reg <= 1'b0;
    end else if (!lost_reg) begin
      if (watch_cnt_reg == 32'(WATCH_CYC - 1)) begin
        lost_reg <= 1'b1; // [R18]
      end else begin
        watch_cnt_reg <= watch_cnt_reg + 32'h0000_0001;
      end
    end
  end

  // Delay in tenths after loss
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tenth_cnt_reg <= 32'h0000_0000;
      tenths_reg <= 8'h00;
    end else if (!lost_reg || fs_reg) begin
      tenth_cnt_reg <= 32'h0000_0000; // [R18]
      tenths_reg <= 8'h00;
    end else if (tenth_cnt_reg == 32'(TENTH_CYC - 1)) begin
      tenth_cnt_reg <= 32'h0000_0000;
      tenths_reg <= tenths_reg + 8'h01; // [R11]
    end else begin
      tenth_cnt_reg <= tenth_cnt_reg + 32'h0000_0001;
    end
  end

  // Entry waits while a host access is completing in the same cycle
  assign enter_now = lost_reg & ~fs_reg & ~host_seen &
                     (tenths_reg >= cfg_reg.delay); // [R10] [R12]

  // Fail-safe state flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fs_reg <= 1'b0;
    end else if (host_seen) begin
      fs_reg <= 1'b0; // [R19]
    end else if (enter_now) begin
      fs_reg <= 1'b1; // [R3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output point drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_reg <= ofs_pkg::OFS_OUT_RST;
    end else if (enter_now) begin
      unique case (cfg_reg.kind)
        ofs_pkg::OFS_KIND_OFF_ALL: out_reg <= 24'h00_0000; // [R4]
        ofs_pkg::OFS_KIND_PATTERN: out_reg <= cfg_reg.pattern; // [R5] [R8]
        ofs_pkg::OFS_KIND_HOLD: out_reg <= out_reg; // [R6]
        KIND_INVALID: out_reg <= 24'h00_0000; // [R7]
      endcase
    end else if (!fs_reg) begin
      out_reg <= host_out_reg; // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: set wins over read-clear
  logic [2:0] irq_evt;
  logic stat_rd;
  logic [2:0] irq_clr;
  assign irq_evt = {lost_reg == 1'b0 && watch_cnt_reg ==
                    32'(WATCH_CYC - 1) && !host_seen,
                    fs_reg & host_seen, enter_now};
  assign stat_rd = rd && paddr == ofs_pkg::OFS_IRQ_OFF;
  // A read clears only the bits it reported in its read data
  assign irq_clr = stat_rd ? prdata[2:0] : 3'h0;

  // Sticky status, an event never lost to a read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 3'h0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_evt;
    end
  end

  // Mask bits, a one hides the matching status bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_reg <= 3'h0;
    end else if (wr && paddr == ofs_pkg::OFS_MASK_OFF && pstrb[0]) begin
      irq_mask_reg <= pwdata[2:0];
    end
  end

  // Level interrupt from unmasked status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_stat_reg & ~irq_clr) | irq_evt) & ~irq_mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus answer: no wait state, registered read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          ofs_pkg::OFS_OUT_OFF: prdata <= {8'h00, host_out_reg};
          ofs_pkg::OFS_STAT_OFF: prdata <= {28'h000_0000, cfg_reg.kind,
                                            lost_reg, fs_reg};
          ofs_pkg::OFS_IRQ_OFF: prdata <= {29'h0000_0000, irq_stat_reg};
          ofs_pkg::OFS_MASK_OFF: prdata <= {29'h0000_0000, irq_mask_reg};
          ofs_pkg::OFS_KEEP_OFF: prdata <= {24'h00_0000, cfg_reg.delay};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign out_points = out_reg;
  assign failsafe_active = fs_reg;

  ////////////////////////////////////////////////////////////////////////
  // Checks: configuration handover
  chk_commit_clear: assert property ( // [R17]
    @(posedge pclk) disable iff (!presetn)
    commit_reg |=> !commit_reg) else $error("commit stuck");
  chk_commit_load: assert property ( // [R15]
    @(posedge pclk) disable iff (!presetn)
    commit_reg |=> cfg_reg.kind == $past(kind_stage_reg) &&
    cfg_reg.delay == $past(delay_stage_reg) &&
    cfg_reg.pattern == $past(pat_stage_reg))
    else $error("commit load wrong");
  chk_stage_hold: assert property ( // [R13]
    @(posedge pclk) disable iff (!presetn)
    !commit_reg |=> $stable(cfg_reg)) else $error("staged leak");
  // Checks: fail-safe entry by kind
  chk_kind_off: assert property ( // [R4]
    @(posedge pclk) disable iff (!presetn)
    enter_now && cfg_reg.kind == ofs_pkg::OFS_KIND_OFF_ALL |=>
    out_points == 24'h00_0000) else $error("off kind");
  chk_kind_pattern: assert property ( // [R5]
    @(posedge pclk) disable iff (!presetn)
    enter_now && cfg_reg.kind == ofs_pkg::OFS_KIND_PATTERN |=>
    out_points == $past(cfg_reg.pattern)) else $error("pattern");
  chk_kind_hold: assert property ( // [R6]
    @(posedge pclk) disable iff (!presetn)
    enter_now && cfg_reg.kind == ofs_pkg::OFS_KIND_HOLD |=>
    $stable(out_points)) else $error("hold kind");
  chk_kind_invalid: assert property ( // [R7]
    @(posedge pclk) disable iff (!presetn)
    enter_now && cfg_reg.kind == KIND_INVALID |=>
    out_points == 24'h00_0000) else $error("invalid kind");
  // Checks: supervision timing, normal drive and resume
  chk_delay_zero: assert property ( // [R12]
    @(posedge pclk) disable iff (!presetn)
    $rose(lost_reg) && cfg_reg.delay == 8'h00 && !host_seen |=>
    failsafe_active) else $error("zero delay");
  chk_no_early: assert property ( // [R10]
    @(posedge pclk) disable iff (!presetn)
    $rose(failsafe_active) |-> $past(tenths_reg) >= cfg_reg.delay)
    else $error("early fail-safe");
  chk_lost_window: assert property ( // [R18]
    @(posedge pclk) disable iff (!presetn)
    $rose(lost_reg) |-> $past(watch_cnt_reg) == 32'(WATCH_CYC - 1))
    else $error("early loss");
  chk_normal_drive: assert property ( // [R1]
    @(posedge pclk) disable iff (!presetn)
    !fs_reg && !enter_now |=> out_points == $past(host_out_reg))
    else $error("normal drive");
  chk_resume: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    fs_reg && host_seen |=> !failsafe_active) else $error("resume");
  chk_seen_clears: assert property ( // [R19]
    @(posedge pclk) disable iff (!presetn)
    host_seen |=> !failsafe_active) else $error("entry with traffic");
  // Checks: bus answer and interrupts
  chk_ready_pulse: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready) else $error("ready stuck");
  chk_pslverr: assert property ( // [R2]
    @(posedge pclk) disable iff (!presetn)
    psel && !penable && !mapped |=> pslverr) else $error("no error");
  chk_irq_masked: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    $past(irq_mask_reg) == 3'h7 |-> !irq) else $error("masked irq");
  chk_irq_sticky: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    !stat_rd |=> (irq_stat_reg & $past(irq_stat_reg)) ==
    $past(irq_stat_reg)) else $error("status lost");
  chk_irq_set_wins: assert property ( // [R3]
    @(posedge pclk) disable iff (!presetn)
    irq_evt[0] |=> irq_stat_reg[0]) else $error("entry event lost");
  // Coverage of the main scenarios
  cov_enter: cover property (@(posedge pclk) $rose(failsafe_active));
  cov_commit: cover property (@(posedge pclk) commit_reg);
  cov_resume: cover property (@(posedge pclk) $fell(failsafe_active));
  cov_pattern: cover property (@(posedge pclk)
    enter_now && cfg_reg.kind == ofs_pkg::OFS_KIND_PATTERN);
  cov_irq_clear: cover property (@(posedge pclk) stat_rd && |irq_clr);
endmodule

// *** bench/ofs_host.sv ***
`timescale 1ns/1ps
// APB master standing in for the remote host
module ofs_host (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // One transfer, held until pready; lanes pick point bytes
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] rd, output logic err, output logic ok);
    int n;
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16 && !ok; n++) begin
      @(posedge pclk);
      ok = (pready === 1'b1);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// *** bench/ofs_port_tb.sv ***
`timescale 1ns/1ps
// Self-checking bench for the fail-safe output port
module ofs_port_tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic failsafe_active, irq, err, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [23:0] out_points;
  int fail_count = 0;
  int n_compared = 0;
  // Point write rows: lanes, data, expected points
  logic [3:0] ws [4] = '{4'h1, 4'h4, 4'h3, 4'hf};
  logic [31:0] wd [4] = '{32'h0000_00ff, 32'h00ff_0000, 32'h1234_0001,
    32'h0012_3456};
  logic [23:0] we [4] = '{24'h00_00ff, 24'hff_00ff, 24'hff_0001,
    24'h12_3456};
  // Fail-safe rows: kind, delay code, expected points; kind 0 is illegal
  logic [1:0] rk [5] = '{2'h1, 2'h2, 2'h3, 2'h1, 2'h0};
  logic [7:0] rdl [5] = '{8'h00, 8'h01, 8'h02, 8'hff, 8'h00};
  logic [23:0] rx [5] = '{24'h00_0000, 24'h5a_a5c3, 24'h12_3456,
    24'h00_0000, 24'h00_0000};

  ofs_port #(.TENTH_CYC(4), .WATCH_CYC(20)) ofs_port_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_points(out_points), .failsafe_active(failsafe_active),
    .irq(irq));

  ofs_host ofs_host_i (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Transfer with timeout handling
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [3:0] s);
    ofs_host_i.xfer(w, a, d, s, rd, err, ok);
    if (ok !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
    input logic [3:0] s = 4'hf);
    bus(1'b1, a, d, s);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp);
  endtask

  // Settle one update past the edge
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    chk({8'h0, out_points}, 32'h0);
    chk({31'h0, failsafe_active | irq}, 32'h0);
    presetn <= 1'b1;
    idle(1);
    rdc(ofs_pkg::OFS_STAT_OFF, 32'h4);
    $display("reset test done");
    // Byte, word and dword point writes
    for (int i = 0; i < 4; i++) begin
      wr(ofs_pkg::OFS_OUT_OFF, wd[i], ws[i]);
      idle(2);
      chk({8'h0, out_points}, {8'h0, we[i]});
      rdc(ofs_pkg::OFS_OUT_OFF, {8'h0, we[i]});
    end
    $display("point table done");
    // Unmapped read is refused with zero data
    bus(1'b0, 12'h040, 32'h0, 4'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Staged values stay inactive without a commit
    wr(ofs_pkg::OFS_PAT_OFF, 32'h005a_a5c3);
    wr(ofs_pkg::OFS_KIND_OFF, 32'h2);
    wr(ofs_pkg::OFS_DELAY_OFF, 32'h5);
    wr(ofs_pkg::OFS_COMMIT_OFF, 32'h0);
    rdc(ofs_pkg::OFS_KEEP_OFF, 32'h0);
    rdc(ofs_pkg::OFS_STAT_OFF, 32'h4);
    $display("staging test done");
    // Each kind with its delay, entered by silence, left by access
    for (int i = 0; i < 5; i++) begin
      wr(ofs_pkg::OFS_KIND_OFF, {30'h0, rk[i]});
      wr(ofs_pkg::OFS_DELAY_OFF, {24'h0, rdl[i]});
      wr(ofs_pkg::OFS_COMMIT_OFF, 32'h1);
      idle(17 + 4 * rdl[i]);
      chk({31'h0, failsafe_active}, 32'h0);
      idle(6);
      chk({31'h0, failsafe_active}, 32'h1);
      chk({8'h0, out_points}, {8'h0, rx[i]});
      rdc(ofs_pkg::OFS_KEEP_OFF, {24'h0, rdl[i]});
      idle(2);
      chk({31'h0, failsafe_active}, 32'h0);
      chk({8'h0, out_points}, 32'h0012_3456);
    end
    $display("fail-safe kinds done");
    // Steady traffic keeps the supervisor quiet
    wr(ofs_pkg::OFS_DELAY_OFF, 32'h0);
    wr(ofs_pkg::OFS_COMMIT_OFF, 32'h1);
    repeat (4) begin
      idle(15);
      wr(ofs_pkg::OFS_MASK_OFF, 32'h7);
    end
    chk({31'h0, failsafe_active}, 32'h0);
    // Masked events, then unmasked, then read clears
    rdc(ofs_pkg::OFS_IRQ_OFF, 32'h7);
    idle(26);
    chk({30'h0, failsafe_active, irq}, 32'h2);
    wr(ofs_pkg::OFS_MASK_OFF, 32'h0);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    rdc(ofs_pkg::OFS_IRQ_OFF, 32'h7);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    rdc(ofs_pkg::OFS_IRQ_OFF, 32'h0);
    $display("interrupt test done");
    // Reset in mid-run clears the points at once, then release
    presetn <= 1'b0;
    #5;
    chk({8'h0, out_points}, 32'h0);
    chk({30'h0, failsafe_active, irq}, 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    idle(1);
    rdc(ofs_pkg::OFS_STAT_OFF, 32'h4);
    rdc(ofs_pkg::OFS_KEEP_OFF, 32'h0);
    chk({8'h0, out_points}, 32'h0);
    $display("second reset done");
    report_and_stop();
  end
endmodule
